// file: dv/ipsc_chk.sv
/*
 Checker of the service link between the two ends.
 Assumes the bench instantiates it beside the link interface.
*/
module ipsc_chk
   import ipsc_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Link signals
   input wire logic req_valid,
   input wire ipsc_op_t req_op,
   input wire logic [BUF_W-1:0] req_buf,
   input wire logic [LEN_W-1:0] req_len,
   input wire logic rsp_valid,
   input wire ipsc_rsp_t rsp_code,
   input wire logic ind_valid,
   input wire ipsc_ind_t ind_kind,
   input wire logic [CONN_W-1:0] ind_conn,
   input wire logic [BUF_W-1:0] ind_buf,
   input wire logic [LEN_W-1:0] ind_cnt,
   input wire logic dlv_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   ipsc_op_t op_q;
   logic arm_q, shut_q, gone_q;
   logic [LEN_W-1:0] max_q, cnt_q;
   logic [BUF_W-1:0] buf_q;
   wire good = rsp_valid && rsp_code == RSP_GOOD;
   wire rcv_ind = ind_valid && ind_kind == IND_RECEIVED;
   wire con_ind = ind_valid && ind_kind == IND_CONNECTED;
   wire rq_new = req_valid && req_op == OP_RECV && !arm_q;
   // Last request kind
   always_ff @(posedge clk_i)
      if (req_valid) op_q <= req_op;
   // Receive outstanding
   always_ff @(posedge clk_i)
      if (rst_i || ind_valid && !con_ind) arm_q <= 1'b0;
      else if (good && op_q == OP_RECV) arm_q <= 1'b1;
   // Receive arguments and delivered count
   always_ff @(posedge clk_i) begin
      if (rq_new) begin
         max_q <= req_len;
         buf_q <= req_buf;
      end
   end
   always_ff @(posedge clk_i)
      if (rst_i || rq_new) cnt_q <= 5'h00;
      else if (dlv_valid) cnt_q <= cnt_q + 5'h01;
   // Close accepted, closed indicated
   always_ff @(posedge clk_i)
      if (rst_i || con_ind) shut_q <= 1'b0;
      else if (good && op_q == OP_CLOSE) shut_q <= 1'b1;
   always_ff @(posedge clk_i)
      if (rst_i || con_ind) gone_q <= 1'b0;
      else if (ind_valid && ind_kind == IND_CLOSED) gone_q <= 1'b1;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_short;
      req_valid && req_op inside {OP_CONNECT, OP_LISTEN, OP_RECV, OP_CLOSE};
   endsequence
   sequence s_send;
      req_valid && req_op == OP_SEND;
   endsequence

   a_short_rsp_next: assert property (s_short |=> rsp_valid)
      else $error("no response one cycle after request");
   a_rsp_single: assert property (rsp_valid |=> !rsp_valid)
      else $error("response strobe longer than one cycle");
   a_send_rsp_bound: assert property (s_send |-> ##[1:80] rsp_valid)
      else $error("send not answered in time");
   a_conn_cause: assert property (con_ind |-> $past(req_valid) &&
      $past(req_op) inside {OP_CONNECT, OP_LISTEN})
      else $error("connected without connect or listen");
   a_conn_id: assert property (con_ind |-> good && ind_conn != CONN_NONE)
      else $error("connected without identifier");
   a_recv_pend: assert property (req_valid && req_op == OP_RECV &&
      req_buf != BUF_NULL && arm_q && !ind_valid
      |=> rsp_valid && rsp_code == RSP_RECV_PEND)
      else $error("second receive not refused");
   a_recv_count: assert property (rcv_ind |-> ind_cnt == cnt_q &&
      ind_cnt <= max_q && ind_buf == buf_q)
      else $error("received count or buffer wrong");
   a_closed_quiet: assert property ((rcv_ind || dlv_valid) |-> !gone_q)
      else $error("delivery after closed");
   a_send_closed: assert property (s_send and shut_q |=>
      rsp_valid && rsp_code == RSP_INV_CONN)
      else $error("send after close not refused");
endmodule

// file: dv/tb.sv
/*
 Bench joining both ends through the link, transmit looped to receive.
 Assumes nothing outside; reset of the far side loops back too.
*/
module tb
   import ipsc_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i, rst_i, cmd_v, ld_v, stall, busy, done_v, ind_v;
   logic close_evt, port_rst, tx_v, tx_rdy, rx_rdy, rst_snd;
   ipsc_op_t op;
   ipsc_rsp_t done_c;
   ipsc_ind_t ind_k;
   logic [BUF_W-1:0] bufid;
   logic [LEN_W-1:0] len, ind_cnt, cur_max;
   logic [CHAR_W-1:0] ld_d, tx_d, rd_d;
   logic [3:0] rd_a, rd_p, conn;
   logic [31:0] seed = 32'h7C6DE782;
   logic [31:0] rv;
   int bad_count = 0;
   int n_checks = 0;
   int rcv_n = 0;
   int evt_n = 0;
   int rp = 0;
   ipsc_rsp_t rq[$];
   ipsc_ind_t kq[$];
   logic [CHAR_W-1:0] cq[$];
   logic [CHAR_W-1:0] rb_m [16];

   ipsc_if lnk();
   ipsc_host ipsc_host_inst (.clk_i(clk_i), .rst_i(rst_i), .port_if(lnk),
      .cmd_valid_i(cmd_v), .cmd_op_i(op), .cmd_buf_i(bufid),
      .cmd_len_i(len), .busy_o(busy), .done_valid_o(done_v),
      .done_code_o(done_c), .ld_valid_i(ld_v), .ld_data_i(ld_d),
      .rd_addr_i(rd_a), .rd_data_o(rd_d), .ind_valid_o(ind_v),
      .ind_kind_o(ind_k), .ind_cnt_o(ind_cnt), .conn_o(conn),
      .close_evt_o(close_evt), .port_reset_o(port_rst));
   ipsc_dev ipsc_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .port_if(lnk),
      .tx_valid_o(tx_v), .tx_data_o(tx_d), .tx_ready_i(tx_rdy),
      .rx_valid_i(tx_v & ~stall), .rx_data_i(tx_d),
      .rx_ready_o(rx_rdy), .rst_send_o(rst_snd), .rst_rcvd_i(rst_snd));
   assign tx_rdy = rx_rdy & ~stall;
   ipsc_chk ipsc_chk_inst (.clk_i(clk_i), .rst_i(rst_i),
      .req_valid(lnk.req_valid), .req_op(lnk.req_op),
      .req_buf(lnk.req_buf), .req_len(lnk.req_len),
      .rsp_valid(lnk.rsp_valid), .rsp_code(lnk.rsp_code),
      .ind_valid(lnk.ind_valid), .ind_kind(lnk.ind_kind),
      .ind_conn(lnk.ind_conn), .ind_buf(lnk.ind_buf),
      .ind_cnt(lnk.ind_cnt), .dlv_valid(lnk.dlv_valid));

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic fail(input logic [31:0] got, input logic [31:0] exp);
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
   endtask

   task automatic final_report();
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // One user command, expected completion code noted first
   task automatic cmd(input ipsc_op_t o, input logic [3:0] b,
         input logic [4:0] l, input ipsc_rsp_t e);
      int i;
      rq.push_back(e);
      @(posedge clk_i);
      cmd_v <= 1'b1;
      op <= o;
      bufid <= b;
      len <= l;
      @(posedge clk_i);
      cmd_v <= 1'b0;
      i = 0;
      do @(negedge clk_i); while (busy !== 1'b0 && ++i < 200);
      if (i >= 200) begin
         bad_count++;
         final_report();
      end
   endtask

   // Fill the send buffer with random characters
   task automatic load(input int n, input bit keep);
      logic [31:0] d;
      repeat (n) begin
         d = xs();
         @(posedge clk_i);
         ld_v <= 1'b1;
         ld_d <= d[7:0];
         if (keep) cq.push_back(d[7:0]);
      end
      @(posedge clk_i);
      ld_v <= 1'b0;
   endtask

   task automatic wait_rcv(input int k);
      int i;
      for (i = 0; i < 300 && rcv_n < k; i++) @(negedge clk_i);
      if (i >= 300) begin
         bad_count++;
         final_report();
      end
   endtask

   // Receive until every sent character is delivered
   task automatic drain(input logic [4:0] m);
      int i;
      cur_max = m;
      for (i = 0; i < 100 && cq.size() != 0; i++) begin
         cmd(OP_RECV, 4'h3, m, RSP_GOOD);
         wait_rcv(rcv_n + 1);
      end
      if (i >= 100) begin
         bad_count++;
         final_report();
      end
   endtask

   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      rv = xs();
      stall <= rv[0];
      rd_a <= rv[7:4];
      rd_p <= rd_a;
   end

   // Result watcher
   always @(negedge clk_i) begin
      ipsc_rsp_t e;
      ipsc_ind_t k;
      logic [CHAR_W-1:0] c;
      if (done_v === 1'b1) begin
         n_checks++;
         e = rq.pop_front();
         if (done_c !== e) fail(done_c, e);
      end
      if (ind_v === 1'b1 && ind_k === IND_RECEIVED) begin
         rcv_n++;
         n_checks++;
         if ((ind_cnt <= cur_max) !== 1'b1) fail(ind_cnt, cur_max);
         if (rd_p < ind_cnt) begin
            n_checks++;
            if (rd_d !== rb_m[rd_p]) fail(rd_d, rb_m[rd_p]);
         end
         rp = 0;
      end else if (ind_v === 1'b1) begin
         n_checks++;
         k = kq.pop_front();
         if (ind_k !== k) fail(ind_k, k);
         n_checks++;
         if ((conn === 4'h0) === (k == IND_CONNECTED)) fail(conn, k);
      end
      if (lnk.dlv_valid === 1'b1) begin
         n_checks++;
         c = cq.pop_front();
         if (lnk.dlv_data !== c) fail(lnk.dlv_data, c);
         rb_m[rp[3:0]] = c;
         rp++;
      end
      if (close_evt === 1'b1 || port_rst === 1'b1) evt_n++;
   end

   initial begin
      rst_i = 1'b1;
      cmd_v = 1'b0;
      ld_v = 1'b0;
      op = OP_CONNECT;
      bufid = 4'h0;
      len = 5'h00;
      ld_d = 8'h00;
      cur_max = 5'h04;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      cmd(OP_SEND, 4'h1, 5'h02, RSP_INV_CONN);
      cmd(OP_RECV, 4'h1, 5'h02, RSP_INV_CONN);
      cmd(OP_CLOSE, 4'h1, 5'h00, RSP_INV_CONN);
      kq.push_back(IND_CONNECTED);
      cmd(OP_CONNECT, 4'h0, 5'h00, RSP_GOOD);
      cmd(OP_LISTEN, 4'h0, 5'h00, RSP_PORT_IN_USE);
      cmd(OP_SEND, 4'h0, 5'h02, RSP_INV_BUF);
      cmd(OP_RECV, 4'h0, 5'h02, RSP_INV_BUF);
      cmd(OP_RECV, 4'h2, 5'h04, RSP_GOOD);
      cmd(OP_RECV, 4'h2, 5'h04, RSP_RECV_PEND);
      load(3, 1'b1);
      cmd(OP_SEND, 4'h1, 5'h03, RSP_GOOD);
      wait_rcv(1);
      drain(5'h04);
      load(5, 1'b1);
      cmd(OP_SEND, 4'h1, 5'h05, RSP_GOOD);
      load(4, 1'b0);
      cmd(OP_SEND, 4'h1, 5'h04, RSP_TX_NO_SPACE);
      load(3, 1'b1);
      cmd(OP_SEND, 4'h1, 5'h03, RSP_GOOD);
      drain(5'h02);
      kq.push_back(IND_CLOSED);
      cmd(OP_CLOSE, 4'h0, 5'h00, RSP_GOOD);
      cmd(OP_SEND, 4'h1, 5'h01, RSP_INV_CONN);
      repeat (4) @(posedge clk_i);
      kq.push_back(IND_CONNECTED);
      cmd(OP_LISTEN, 4'h0, 5'h00, RSP_GOOD);
      kq.push_back(IND_RESET_RCVD);
      cmd(OP_RESET, 4'h0, 5'h00, RSP_GOOD);
      repeat (6) @(posedge clk_i);
      n_checks++;
      if (evt_n !== 2) fail(evt_n, 2);
      n_checks++;
      if (rq.size() + kq.size() != 0) fail(rq.size(), kq.size());
      n_checks++;
      if (cq.size() != 0) fail(cq.size(), 0);
      final_report();
   end
endmodule

// file: rtl/ipsc_dev.sv
/*
 Interconnect port end: service request handling, transmit queue and
 receive delivery. Assumes the link side runs on clk_i and that the
 word FIFO module is compiled with it.
*/
module ipsc_dev
   import ipsc_pkg::*;
#(
   parameter int DEPTH = TXQ_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Service link
   ipsc_if.dev port_if,
   // Transmit characters
   output logic tx_valid_o,
   output logic [CHAR_W-1:0] tx_data_o,
   input wire logic tx_ready_i,
   // Receive characters
   input wire logic rx_valid_i,
   input wire logic [CHAR_W-1:0] rx_data_i,
   output logic rx_ready_o,
   // Port reset to and from the far end
   output logic rst_send_o,
   input wire logic rst_rcvd_i
);
   localparam int LW = $clog2(DEPTH+1);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_OPEN = 2'b01,
      ST_COPY = 2'b10,
      ST_CLOSING = 2'b11
   } ipsc_dst_t;

   ipsc_dst_t st_q;
   logic [CONN_W-1:0] conn_q, next_id_q, ind_conn_q;
   logic rsp_valid_q, ind_valid_q, wr_ready_q, rcv_act_q, rx_ready_q;
   ipsc_rsp_t rsp_code_q;
   ipsc_ind_t ind_kind_q;
   logic [BUF_W-1:0] ind_buf_q, rcv_buf_q;
   logic [LEN_W-1:0] ind_cnt_q, left_q, rcv_max_q, rcv_cnt_q;
   logic dlv_valid_q, rst_send_q;
   logic [CHAR_W-1:0] dlv_data_q;
   logic [LW-1:0] level;
   logic txq_ready, req, conn_ok, buf_ok, space_ok, wr_take, rx_take;
   logic conn_go, close_go, rcv_go, rcv_done, closed_go;

   assign req = port_if.req_valid;
   assign conn_ok = st_q == ST_OPEN && port_if.req_conn == conn_q;
   assign buf_ok = port_if.req_buf != BUF_NULL;
   assign space_ok = int'(port_if.req_len) <= DEPTH - int'(level);
   assign wr_take = port_if.wr_valid & wr_ready_q & txq_ready;
   assign rx_take = rx_valid_i & rx_ready_q;
   assign conn_go = req && st_q == ST_IDLE && !rst_rcvd_i &&
      (port_if.req_op == OP_CONNECT || port_if.req_op == OP_LISTEN);
   assign close_go = req && port_if.req_op == OP_CLOSE && conn_ok;
   assign rcv_go = req && port_if.req_op == OP_RECV && conn_ok && buf_ok &&
      !rcv_act_q;
   // Chunk ends at max, first gap after data, or on close
   assign rcv_done = rcv_act_q && (rcv_cnt_q == rcv_max_q ||
      (rx_ready_q && !rx_valid_i && rcv_cnt_q != '0) ||
      st_q == ST_CLOSING);
   assign closed_go = st_q == ST_CLOSING && !rcv_act_q && level == '0 &&
      !req && !rst_rcvd_i;

   assign port_if.rsp_valid = rsp_valid_q;
   assign port_if.rsp_code = rsp_code_q;
   assign port_if.ind_valid = ind_valid_q;
   assign port_if.ind_kind = ind_kind_q;
   assign port_if.ind_conn = ind_conn_q;
   assign port_if.ind_buf = ind_buf_q;
   assign port_if.ind_cnt = ind_cnt_q;
   assign port_if.wr_ready = wr_ready_q;
   assign port_if.dlv_valid = dlv_valid_q;
   assign port_if.dlv_data = dlv_data_q;
   assign rx_ready_o = rx_ready_q;
   assign rst_send_o = rst_send_q;

   // Own copy of send data, drained in order
   ipsc_txq #(
      .W(CHAR_W),
      .D(DEPTH)
   ) u_txq (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(wr_take),
      .in_data_i(port_if.wr_data),
      .in_ready_o(txq_ready),
      .out_valid_o(tx_valid_o),
      .out_data_o(tx_data_o),
      .out_ready_i(tx_ready_i),
      .level_o(level)
   );

   // Connection state and request answers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= ST_IDLE;
         conn_q <= CONN_NONE;
         next_id_q <= CONN_FIRST;
         rsp_valid_q <= 1'b0;
         rsp_code_q <= RSP_GOOD;
         left_q <= '0;
         wr_ready_q <= 1'b0;
         rst_send_q <= 1'b0;
      end else begin
         rsp_valid_q <= 1'b0;
         rst_send_q <= 1'b0;
         if (rst_rcvd_i) begin
            st_q <= ST_IDLE;
            wr_ready_q <= 1'b0;
         end else if (st_q == ST_COPY) begin
            if (wr_take) begin
               left_q <= left_q - 1'b1;
               if (left_q == LEN_W'(1)) begin
                  wr_ready_q <= 1'b0;
                  st_q <= ST_OPEN;
                  rsp_valid_q <= 1'b1;
                  rsp_code_q <= RSP_GOOD;
               end
            end
         end else if (req) begin
            rsp_valid_q <= 1'b1;
            case (port_if.req_op)
               OP_CONNECT, OP_LISTEN: begin
                  if (conn_go) begin
                     conn_q <= next_id_q;
                     next_id_q <= (next_id_q == '1) ? CONN_FIRST :
                        next_id_q + 1'b1;
                     st_q <= ST_OPEN;
                     rsp_code_q <= RSP_GOOD;
                  end else begin
                     rsp_code_q <= RSP_PORT_IN_USE;
                  end
               end
               OP_SEND: begin
                  if (!conn_ok) begin
                     rsp_code_q <= RSP_INV_CONN;
                  end else if (!buf_ok) begin
                     rsp_code_q <= RSP_INV_BUF;
                  end else if (!space_ok) begin
                     rsp_code_q <= RSP_TX_NO_SPACE;
                  end else if (port_if.req_len == '0) begin
                     rsp_code_q <= RSP_GOOD;
                  end else begin
                     rsp_valid_q <= 1'b0;
                     st_q <= ST_COPY;
                     left_q <= port_if.req_len;
                     wr_ready_q <= 1'b1;
                  end
               end
               OP_RECV: begin
                  if (!conn_ok) begin
                     rsp_code_q <= RSP_INV_CONN;
                  end else if (!buf_ok) begin
                     rsp_code_q <= RSP_INV_BUF;
                  end else if (rcv_act_q) begin
                     rsp_code_q <= RSP_RECV_PEND;
                  end else begin
                     rsp_code_q <= RSP_GOOD;
                  end
               end
               OP_CLOSE: begin
                  if (close_go) begin
                     st_q <= ST_CLOSING;
                     rsp_code_q <= RSP_GOOD;
                  end else begin
                     rsp_code_q <= RSP_INV_CONN;
                  end
               end
               OP_RESET: begin
                  rst_send_q <= 1'b1;
                  rsp_code_q <= RSP_GOOD;
               end
               default: begin
                  rsp_code_q <= RSP_BAD_OP;
               end
            endcase
         end else if (closed_go) begin
            st_q <= ST_IDLE;
         end
      end
   end

   // Outstanding receive and character delivery
   always_ff @(posedge clk_i) begin
      if (rst_i || rst_rcvd_i) begin
         rcv_act_q <= 1'b0;
         rcv_buf_q <= BUF_NULL;
         rcv_max_q <= '0;
         rcv_cnt_q <= '0;
         rx_ready_q <= 1'b0;
         dlv_valid_q <= 1'b0;
         dlv_data_q <= '0;
      end else begin
         dlv_valid_q <= rx_take;
         if (rx_take) begin
            dlv_data_q <= rx_data_i;
         end
         if (rcv_done) begin
            rcv_act_q <= 1'b0;
            rx_ready_q <= 1'b0;
         end else if (rcv_go) begin
            rcv_act_q <= 1'b1;
            rcv_buf_q <= port_if.req_buf;
            rcv_max_q <= port_if.req_len;
            rcv_cnt_q <= '0;
            rx_ready_q <= port_if.req_len != '0;
         end else begin
            if (rx_take) begin
               rcv_cnt_q <= rcv_cnt_q + 1'b1;
            end
            rx_ready_q <= rcv_act_q && st_q == ST_OPEN && !close_go &&
               (rx_take ? rcv_cnt_q + 1'b1 < rcv_max_q :
               rcv_cnt_q < rcv_max_q);
         end
      end
   end

   // Indications, one at a time
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ind_valid_q <= 1'b0;
         ind_kind_q <= IND_CONNECTED;
         ind_conn_q <= CONN_NONE;
         ind_buf_q <= BUF_NULL;
         ind_cnt_q <= '0;
      end else begin
         ind_valid_q <= rst_rcvd_i | conn_go | rcv_done | closed_go;
         ind_conn_q <= conn_q;
         if (rst_rcvd_i) begin
            ind_kind_q <= IND_RESET_RCVD;
         end else if (conn_go) begin
            ind_kind_q <= IND_CONNECTED;
            ind_conn_q <= next_id_q;
         end else if (rcv_done) begin
            ind_kind_q <= IND_RECEIVED;
            ind_buf_q <= rcv_buf_q;
            ind_cnt_q <= rcv_cnt_q;
         end else if (closed_go) begin
            ind_kind_q <= IND_CLOSED;
         end
      end
   end
endmodule

// file: rtl/ipsc_host.sv
/*
 Upper transport port end: issues service requests one at a time, holds
 the send and receive buffers. Assumes a single clk_i with the far end.
 Also holds the word FIFO that the interconnect end keeps its copy in.
*/
module ipsc_host
   import ipsc_pkg::*;
#(
   parameter bit AUTOMATION = 1'b1,
   parameter int SBUF = SBUF_DEPTH,
   parameter int RBUF = RBUF_DEPTH
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Service link
   ipsc_if.host port_if,
   // User commands
   input wire logic cmd_valid_i,
   input wire ipsc_op_t cmd_op_i,
   input wire logic [BUF_W-1:0] cmd_buf_i,
   input wire logic [LEN_W-1:0] cmd_len_i,
   output logic busy_o,
   output logic done_valid_o,
   output ipsc_rsp_t done_code_o,
   // Send buffer fill
   input wire logic ld_valid_i,
   input wire logic [CHAR_W-1:0] ld_data_i,
   // Receive buffer read
   input wire logic [$clog2(RBUF)-1:0] rd_addr_i,
   output logic [CHAR_W-1:0] rd_data_o,
   // Indication report
   output logic ind_valid_o,
   output ipsc_ind_t ind_kind_o,
   output logic [LEN_W-1:0] ind_cnt_o,
   output logic [CONN_W-1:0] conn_o,
   output logic close_evt_o,
   output logic port_reset_o
);
   localparam int SW = $clog2(SBUF);
   localparam int RW = $clog2(RBUF);

   logic [CHAR_W-1:0] sbuf_q [SBUF];
   logic [CHAR_W-1:0] rbuf_q [RBUF];
   logic [SW-1:0] ld_ptr_q;
   logic [SW-1:0] sidx_q;
   logic [RW-1:0] rptr_q;
   logic [LEN_W-1:0] left_q;
   logic wr_take;
   logic ind_rst;

   assign wr_take = port_if.wr_valid & port_if.wr_ready;
   assign ind_rst = port_if.ind_valid && port_if.ind_kind == IND_RESET_RCVD;

   // Buffer storage
   for (genvar i = 0; i < SBUF; i++) begin : g_sbuf
      always_ff @(posedge clk_i) begin
         if (ld_valid_i && ld_ptr_q == SW'(i)) begin
            sbuf_q[i] <= ld_data_i;
         end
      end
   end
   for (genvar i = 0; i < RBUF; i++) begin : g_rbuf
      always_ff @(posedge clk_i) begin
         if (port_if.dlv_valid && rptr_q == RW'(i)) begin
            rbuf_q[i] <= port_if.dlv_data;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      rd_data_o <= rbuf_q[rd_addr_i];
   end

   // Request issue and completion
   always_ff @(posedge clk_i) begin
      if (rst_i || ind_rst) begin
         busy_o <= 1'b0;
         done_valid_o <= 1'b0;
         done_code_o <= RSP_GOOD;
         port_if.req_valid <= 1'b0;
         port_if.req_op <= OP_CONNECT;
         port_if.req_conn <= CONN_NONE;
         port_if.req_buf <= BUF_NULL;
         port_if.req_len <= '0;
         port_if.wr_valid <= 1'b0;
         port_if.wr_data <= '0;
         sidx_q <= '0;
         left_q <= '0;
         ld_ptr_q <= '0;
      end else begin
         port_if.req_valid <= 1'b0;
         done_valid_o <= 1'b0;
         if (ld_valid_i) begin
            ld_ptr_q <= ld_ptr_q + 1'b1;
         end
         if (!busy_o && cmd_valid_i) begin
            if (cmd_op_i == OP_RESET && !AUTOMATION) begin
               done_valid_o <= 1'b1;
               done_code_o <= RSP_BAD_OP;
            end else begin
               busy_o <= 1'b1;
               port_if.req_valid <= 1'b1;
               port_if.req_op <= cmd_op_i;
               port_if.req_conn <= conn_o;
               port_if.req_buf <= cmd_buf_i;
               port_if.req_len <= cmd_len_i;
               if (cmd_op_i == OP_SEND) begin
                  port_if.wr_valid <= cmd_len_i != '0;
                  port_if.wr_data <= sbuf_q[0];
                  sidx_q <= '0;
                  left_q <= cmd_len_i;
               end
            end
         end else if (port_if.rsp_valid) begin
            // Good send means queued, not yet on the wire
            busy_o <= 1'b0;
            done_valid_o <= 1'b1;
            done_code_o <= port_if.rsp_code;
            port_if.wr_valid <= 1'b0;
            if (port_if.req_op == OP_SEND) begin
               ld_ptr_q <= '0;
            end
         end else if (wr_take) begin
            sidx_q <= sidx_q + 1'b1;
            left_q <= left_q - 1'b1;
            port_if.wr_data <= sbuf_q[sidx_q + 1'b1];
            port_if.wr_valid <= left_q != LEN_W'(1);
         end
      end
   end

   // Indication handling
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conn_o <= CONN_NONE;
         ind_valid_o <= 1'b0;
         ind_kind_o <= IND_CONNECTED;
         ind_cnt_o <= '0;
         close_evt_o <= 1'b0;
         port_reset_o <= 1'b0;
         rptr_q <= '0;
      end else begin
         ind_valid_o <= port_if.ind_valid;
         close_evt_o <= 1'b0;
         port_reset_o <= ind_rst;
         if (port_if.dlv_valid) begin
            rptr_q <= rptr_q + 1'b1;
         end
         if (port_if.ind_valid) begin
            ind_kind_o <= port_if.ind_kind;
            ind_cnt_o <= port_if.ind_cnt;
            case (port_if.ind_kind)
               IND_CONNECTED: begin
                  conn_o <= port_if.ind_conn;
               end
               IND_RECEIVED: begin
                  rptr_q <= '0;
               end
               IND_CLOSED: begin
                  close_evt_o <= 1'b1;
                  conn_o <= CONN_NONE;
               end
               default: begin
                  conn_o <= CONN_NONE;
                  rptr_q <= '0;
               end
            endcase
         end
      end
   end
endmodule

module ipsc_txq #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Fill side
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   // Drain side
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i,
   // Fill level
   output logic [$clog2(D+1)-1:0] level_o
);
   localparam int AW = $clog2(D);
   localparam int LW = $clog2(D+1);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [LW-1:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready_o = cnt_q != LW'(D);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o = mem_q[rd_q];
   assign level_o = cnt_q;
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   // Storage, one flop word per entry
   for (genvar i = 0; i < D; i++) begin : g_ent
      always_ff @(posedge clk_i) begin
         if (push && wr_q == AW'(i)) begin
            mem_q[i] <= in_data_i;
         end
      end
   end

   // Strict arrival order keeps earlier sends ahead
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
         end
         if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// file: rtl/ipsc_if.sv
/*
 Service link between the upper transport port and the interconnect port.
 Assumes both ends share one clock; the bench instantiates it.
*/
interface ipsc_if;
   import ipsc_pkg::*;
   // Requests
   logic req_valid;
   ipsc_op_t req_op;
   logic [CONN_W-1:0] req_conn;
   logic [BUF_W-1:0] req_buf;
   logic [LEN_W-1:0] req_len;
   // Responses
   logic rsp_valid;
   ipsc_rsp_t rsp_code;
   // Indications
   logic ind_valid;
   ipsc_ind_t ind_kind;
   logic [CONN_W-1:0] ind_conn;
   logic [BUF_W-1:0] ind_buf;
   logic [LEN_W-1:0] ind_cnt;
   // Send buffer copy
   logic wr_valid;
   logic [CHAR_W-1:0] wr_data;
   logic wr_ready;
   // Received characters into the receive buffer
   logic dlv_valid;
   logic [CHAR_W-1:0] dlv_data;

   modport dev (
      input req_valid, req_op, req_conn, req_buf, req_len,
      output rsp_valid, rsp_code,
      output ind_valid, ind_kind, ind_conn, ind_buf, ind_cnt,
      input wr_valid, wr_data,
      output wr_ready, dlv_valid, dlv_data
   );
   modport host (
      output req_valid, req_op, req_conn, req_buf, req_len,
      input rsp_valid, rsp_code,
      input ind_valid, ind_kind, ind_conn, ind_buf, ind_cnt,
      output wr_valid, wr_data,
      input wr_ready, dlv_valid, dlv_data
   );
endinterface

// file: rtl/ipsc_pkg.sv
/*
 Shared constants and types of the interconnect port service link.
 Assumes both ends and the link interface import it.
*/
package ipsc_pkg;
   // Field widths and depths
   localparam int CHAR_W = 8;
   localparam int LEN_W = 5;
   localparam int CONN_W = 4;
   localparam int BUF_W = 4;
   localparam int TXQ_DEPTH = 8;
   localparam int SBUF_DEPTH = 16;
   localparam int RBUF_DEPTH = 16;
   // Reserved values and first connection identifier
   localparam logic [BUF_W-1:0] BUF_NULL = 4'h0;
   localparam logic [CONN_W-1:0] CONN_NONE = 4'h0;
   localparam logic [CONN_W-1:0] CONN_FIRST = 4'h1;

   typedef enum logic [2:0] {
      OP_CONNECT = 3'h0,
      OP_LISTEN = 3'h1,
      OP_SEND = 3'h2,
      OP_RECV = 3'h3,
      OP_CLOSE = 3'h4,
      OP_RESET = 3'h5
   } ipsc_op_t;

   typedef enum logic [2:0] {
      RSP_GOOD = 3'h0,
      RSP_INV_CONN = 3'h1,
      RSP_INV_BUF = 3'h2,
      RSP_TX_NO_SPACE = 3'h3,
      RSP_RECV_PEND = 3'h4,
      RSP_PORT_IN_USE = 3'h5,
      RSP_BAD_OP = 3'h6
   } ipsc_rsp_t;

   typedef enum logic [1:0] {
      IND_CONNECTED = 2'h0,
      IND_RECEIVED = 2'h1,
      IND_CLOSED = 2'h2,
      IND_RESET_RCVD = 2'h3
   } ipsc_ind_t;
endpackage
